// >>> rtl/hb_pkg.sv
// constants and carrier types for the half-bridge interlock and fault latch
package hb_pkg;
  localparam int CLK_MHZ = 25;
  // times in ns; every count rounds up to whole clock cycles
  localparam int DT4_NS = 4000;
  localparam int DT3_NS = 3000;
  localparam int DT2_NS = 2000;
  localparam int DT1_NS = 1000;
  localparam int IDLE_NS = 9000;
  localparam int REL6_NS = 16000;
  localparam int REL7_NS = 7000;
  localparam int ERR_NS = 1300;
  localparam int BLANK_NS = 3500;
  localparam int DT4_CYC = (DT4_NS * CLK_MHZ + 999) / 1000;
  localparam int DT3_CYC = (DT3_NS * CLK_MHZ + 999) / 1000;
  localparam int DT2_CYC = (DT2_NS * CLK_MHZ + 999) / 1000;
  localparam int DT1_CYC = (DT1_NS * CLK_MHZ + 999) / 1000;
  localparam int IDLE_CYC = (IDLE_NS * CLK_MHZ + 999) / 1000;
  localparam int REL6_CYC = (REL6_NS * CLK_MHZ + 999) / 1000;
  localparam int REL7_CYC = (REL7_NS * CLK_MHZ + 999) / 1000;
  localparam int ERR_CYC = (ERR_NS * CLK_MHZ + 999) / 1000;
  localparam int BLANK_CYC = (BLANK_NS * CLK_MHZ + 999) / 1000;
  // register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_IRQ_STAT = 8'h08;
  localparam logic [7:0] REG_IRQ_CLR = 8'h0C;
  localparam logic [7:0] REG_IRQ_EN = 8'h10;
  // control fields
  localparam int CTRL_DESAT_EN = 0;
  localparam int CTRL_SW_FAULT = 1;
  localparam logic [1:0] CTRL_RST = 2'h1;
  // interrupt bits
  localparam int IRQ_LATCH = 0;
  localparam int IRQ_REL = 1;
  localparam int IRQ_CHOP = 2;
  localparam logic [2:0] IRQ_RST = 3'h0;
  // status fields
  localparam int ST_LATCH = 0;
  localparam int ST_PEND = 1;
  localparam int ST_CHOP = 2;
  localparam int ST_NOILK = 3;
  localparam int ST_DTA = 4;
  localparam int ST_DTB = 5;

  typedef struct packed {
    logic [2:0] high;
    logic [2:0] low;
  } bridge_t;

  typedef enum logic [2:0] {
    FS_RUN   = 3'h1,
    FS_DELAY = 3'h2,
    FS_LATCH = 3'h4
  } fault_st_t;
endpackage

// >>> rtl/halfbridge_interlock_fault_latch.sv
// gate command interlock, fault latch and chopper fault for three half-bridges
// Functional notes
// - command high means switch on
// - external fault low forces the six gate outputs off
// - fault output driven low or high
// - clear needs no source, six low >9us
// - release 16us six, 7us chopper
// - chopper fault output is open drain
// - chopper fault only while its command high
// - chopper fault may feed external input
// - dead time after partner turns off
// - straps pick 4/3/2/1 us dead time
// - disable strap grounded removes interlock
// - logic runs from one system clock
// - fault indication about 1.3us after event
// - desaturation check blanked after turn-on
module halfbridge_interlock_fault_latch (
  input  wire logic           mclk_i,
  input  wire logic           reset_n_i,
  input  wire hb_pkg::bridge_t cmd_i,
  input  wire logic           chopper_cmd_in_i,
  input  wire logic           ext_fault_in_n_i,
  input  wire logic           deadtime_strap_a_n_i,
  input  wire logic           deadtime_strap_b_n_i,
  input  wire logic           interlock_off_n_i,
  input  wire logic [6:0]     desat_i,
  output hb_pkg::bridge_t     gate_o,
  output logic                chopper_gate_o,
  output logic                fault_n_o,
  output logic                chopper_fault_out_n_o,
  output logic                chopper_fault_oe_o,
  output logic                irq_o,
  input  wire logic           wb_cyc_i,
  input  wire logic           wb_stb_i,
  input  wire logic           wb_we_i,
  input  wire logic [7:0]     wb_adr_i,
  input  wire logic [3:0]     wb_sel_i,
  input  wire logic [31:0]    wb_dat_i,
  output logic [31:0]         wb_dat_o,
  output logic                wb_ack_o
);
  //////////////////////////////////////////////////////////////////////////
  // declarations
  hb_pkg::bridge_t   gate_ff, nxt_gate;
  hb_pkg::fault_st_t st_ff, nxt_st;
  logic [9:0]  cnt_ff, nxt_cnt;
  logic [6:0]  dt_ff [3], nxt_dt [3];
  logic [6:0]  bl_ff [7], nxt_bl [7];
  logic [6:0]  dt_cyc;
  logic [6:0]  on_w, hit_w;
  logic        noilk, src, clear_ok, blocked;
  logic        chop_gate_ff, nxt_chop_gate, chop_flt_ff, nxt_chop_flt;
  logic        chop_ind_ff, nxt_chop_ind;
  logic [7:0]  chop_cnt_ff, nxt_chop_cnt;
  logic [1:0]  ctrl_ff, nxt_ctrl;
  logic [2:0]  irq_st_ff, nxt_irq_st, irq_en_ff, nxt_irq_en, ev;
  logic        ack_ff, nxt_ack;
  logic [31:0] rd_ff, nxt_rd;
  logic        req, wr;

  //////////////////////////////////////////////////////////////////////////
  // strap decode; grounded strap reads low
  // interlock removed
  assign noilk = ~interlock_off_n_i;
  always_comb begin
    unique case ({deadtime_strap_a_n_i, deadtime_strap_b_n_i})
      2'h3:    dt_cyc = 7'(hb_pkg::DT4_CYC);
      2'h2:    dt_cyc = 7'(hb_pkg::DT3_CYC);
      2'h1:    dt_cyc = 7'(hb_pkg::DT2_CYC);
      default: dt_cyc = 7'(hb_pkg::DT1_CYC);
    endcase
  end

  //////////////////////////////////////////////////////////////////////////
  // blanking counters: desaturation counts only once blank time is over
  assign on_w = {chop_gate_ff, gate_ff.high, gate_ff.low};
  for (genvar c = 0; c < 7; c++) begin : g_blank
    always_comb begin
      nxt_bl[c] = 7'h00;
      if (on_w[c]) begin
        nxt_bl[c] = bl_ff[c];
        if (bl_ff[c] != 7'(hb_pkg::BLANK_CYC)) begin
          nxt_bl[c] = bl_ff[c] + 7'h01;
        end
      end
    end
    assign hit_w[c] = on_w[c] & desat_i[c] & ctrl_ff[hb_pkg::CTRL_DESAT_EN]
                      & (bl_ff[c] == 7'(hb_pkg::BLANK_CYC));
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
        bl_ff[c] <= 7'h00;
      end else begin
        bl_ff[c] <= nxt_bl[c];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // six-channel fault state: delay, latch, idle-then-release
  assign src = ~ext_fault_in_n_i | ctrl_ff[hb_pkg::CTRL_SW_FAULT] | (|hit_w[5:0]);
  assign clear_ok = ~src & ~(|cmd_i.high) & ~(|cmd_i.low);
  assign blocked = (st_ff != hb_pkg::FS_RUN) | src;
  // intervals as cycle counts
  // any break in the idle span restarts the count, so short gaps never clear
  always_comb begin
    nxt_st = st_ff;
    nxt_cnt = 10'h000;
    unique case (st_ff)
      hb_pkg::FS_RUN: begin
        if (src) begin
          nxt_st = hb_pkg::FS_DELAY;
        end
      end
      hb_pkg::FS_DELAY: begin
        nxt_cnt = cnt_ff + 10'h001;
        if (cnt_ff == 10'(hb_pkg::ERR_CYC - 2)) begin
          nxt_st = hb_pkg::FS_LATCH;
          nxt_cnt = 10'h000;
        end
      end
      hb_pkg::FS_LATCH: begin
        if (clear_ok) begin
          nxt_cnt = cnt_ff + 10'h001;
          if (cnt_ff == 10'(hb_pkg::IDLE_CYC + hb_pkg::REL6_CYC)) begin
            nxt_st = hb_pkg::FS_RUN;
            nxt_cnt = 10'h000;
          end
        end
      end
    endcase
  end
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      st_ff <= hb_pkg::FS_RUN;
      cnt_ff <= 10'h000;
    end else begin
      st_ff <= nxt_st;
      cnt_ff <= nxt_cnt;
    end
  end
  assign fault_n_o = (st_ff != hb_pkg::FS_LATCH);

  //////////////////////////////////////////////////////////////////////////
  // interlock per half-bridge
  for (genvar b = 0; b < 3; b++) begin : g_ilk
    logic dt_ok;
    always_comb begin
      nxt_dt[b] = 7'h00;
      if (!gate_ff.high[b] && !gate_ff.low[b]) begin
        nxt_dt[b] = dt_ff[b];
        if (dt_ff[b] != 7'h7F) begin
          nxt_dt[b] = dt_ff[b] + 7'h01;
        end
      end
    end
    assign dt_ok = dt_ff[b] >= dt_cyc;
    always_comb begin
      nxt_gate.high[b] = cmd_i.high[b];
      nxt_gate.low[b] = cmd_i.low[b];
      if (!noilk) begin
        nxt_gate.high[b] = cmd_i.high[b] & ~cmd_i.low[b]
                           & (gate_ff.high[b] | (~gate_ff.low[b] & dt_ok));
        nxt_gate.low[b] = cmd_i.low[b] & ~cmd_i.high[b]
                          & (gate_ff.low[b] | (~gate_ff.high[b] & dt_ok));
      end
      if (blocked) begin
        nxt_gate.high[b] = 1'b0;
        nxt_gate.low[b] = 1'b0;
      end
    end
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
        dt_ff[b] <= 7'h00;
      end else begin
        dt_ff[b] <= nxt_dt[b];
      end
    end
  end
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      gate_ff <= '0;
    end else begin
      gate_ff <= nxt_gate;
    end
  end
  // external fault cuts gates at once, without waiting a clock
  assign gate_o.high = gate_ff.high & {3{ext_fault_in_n_i}};
  assign gate_o.low = gate_ff.low & {3{ext_fault_in_n_i}};

  //////////////////////////////////////////////////////////////////////////
  // chopper channel: independent of the six bridge commands
  // its flag keeps its own count; the six-channel latch never clears it
  // chopper fault gated by its command
  always_comb begin
    nxt_chop_flt = chop_flt_ff | hit_w[6];
    nxt_chop_cnt = 8'h00;
    if (chopper_cmd_in_i == 1'b0 && chop_flt_ff) begin
      nxt_chop_cnt = chop_cnt_ff + 8'h01;
      if (chop_cnt_ff == 8'(hb_pkg::REL7_CYC - 1)) begin
        nxt_chop_flt = 1'b0;
      end
    end
    nxt_chop_gate = chopper_cmd_in_i & ~nxt_chop_flt;
    nxt_chop_ind = nxt_chop_flt & chopper_cmd_in_i;
  end
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      chop_flt_ff <= 1'b0;
      chop_cnt_ff <= 8'h00;
      chop_gate_ff <= 1'b0;
      chop_ind_ff <= 1'b0;
    end else begin
      chop_flt_ff <= nxt_chop_flt;
      chop_cnt_ff <= nxt_chop_cnt;
      chop_gate_ff <= nxt_chop_gate;
      chop_ind_ff <= nxt_chop_ind;
    end
  end
  assign chopper_gate_o = chop_gate_ff;
  assign chopper_fault_out_n_o = 1'b0;
  assign chopper_fault_oe_o = chop_ind_ff;

  //////////////////////////////////////////////////////////////////////////
  // interrupt events; a set in the clear cycle survives
  assign ev[hb_pkg::IRQ_LATCH] = (nxt_st == hb_pkg::FS_LATCH) & (st_ff != hb_pkg::FS_LATCH);
  assign ev[hb_pkg::IRQ_REL] = (nxt_st == hb_pkg::FS_RUN) & (st_ff == hb_pkg::FS_LATCH);
  assign ev[hb_pkg::IRQ_CHOP] = nxt_chop_flt & ~chop_flt_ff;
  assign irq_o = |(irq_st_ff & irq_en_ff);

  //////////////////////////////////////////////////////////////////////////
  // classic wishbone slave, one wait state, unmapped reads give zero
  // only byte lane 0 carries fields, so writes without sel[0] are dropped
  assign req = wb_cyc_i & wb_stb_i & ~ack_ff;
  assign wr = req & wb_we_i & wb_sel_i[0];
  always_comb begin
    nxt_ack = req;
    nxt_ctrl = ctrl_ff;
    nxt_irq_en = irq_en_ff;
    nxt_irq_st = irq_st_ff;
    nxt_rd = rd_ff;
    if (wr && wb_adr_i == hb_pkg::REG_CTRL) begin
      nxt_ctrl = wb_dat_i[1:0];
    end
    if (wr && wb_adr_i == hb_pkg::REG_IRQ_EN) begin
      nxt_irq_en = wb_dat_i[2:0];
    end
    if (wr && wb_adr_i == hb_pkg::REG_IRQ_CLR) begin
      nxt_irq_st = irq_st_ff & ~wb_dat_i[2:0];
    end
    nxt_irq_st = nxt_irq_st | ev;
    if (req && !wb_we_i) begin
      nxt_rd = 32'h0000_0000;
      unique case (wb_adr_i)
        hb_pkg::REG_CTRL:     nxt_rd[1:0] = ctrl_ff;
        hb_pkg::REG_IRQ_STAT: nxt_rd[2:0] = irq_st_ff;
        hb_pkg::REG_IRQ_EN:   nxt_rd[2:0] = irq_en_ff;
        hb_pkg::REG_STATUS: begin
          nxt_rd[hb_pkg::ST_LATCH] = (st_ff == hb_pkg::FS_LATCH);
          nxt_rd[hb_pkg::ST_PEND] = (st_ff == hb_pkg::FS_DELAY);
          nxt_rd[hb_pkg::ST_CHOP] = chop_ind_ff;
          nxt_rd[hb_pkg::ST_NOILK] = noilk;
          nxt_rd[hb_pkg::ST_DTA] = deadtime_strap_a_n_i;
          nxt_rd[hb_pkg::ST_DTB] = deadtime_strap_b_n_i;
        end
        default: nxt_rd = 32'h0000_0000;
      endcase
    end
  end
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ack_ff <= 1'b0;
      ctrl_ff <= hb_pkg::CTRL_RST;
      irq_en_ff <= hb_pkg::IRQ_RST;
      irq_st_ff <= hb_pkg::IRQ_RST;
      rd_ff <= 32'h0000_0000;
    end else begin
      ack_ff <= nxt_ack;
      ctrl_ff <= nxt_ctrl;
      irq_en_ff <= nxt_irq_en;
      irq_st_ff <= nxt_irq_st;
      rd_ff <= nxt_rd;
    end
  end
  assign wb_ack_o = ack_ff;
  assign wb_dat_o = rd_ff;
endmodule

// >>> dv/hb_chk.sv
// checker for the interlock and fault latch, bound to the top module
module hb_chk (
  input wire logic            mclk_i,
  input wire logic            reset_n_i,
  input wire hb_pkg::bridge_t cmd_i,
  input wire logic            chopper_cmd_in_i,
  input wire logic            ext_fault_in_n_i,
  input wire logic            interlock_off_n_i,
  input wire hb_pkg::bridge_t gate_o,
  input wire logic            fault_n_o,
  input wire logic            chopper_fault_out_n_o,
  input wire logic            chopper_fault_oe_o,
  input wire logic            wb_cyc_i,
  input wire logic            wb_stb_i,
  input wire logic            wb_ack_o
);
  timeunit 1ns;
  timeprecision 1ns;
  int unsigned idle_ff;
  int unsigned nxt_idle;
  // idle span: all six commands low, no external fault; any break restarts it
  always_comb begin
    nxt_idle = (cmd_i == '0 && ext_fault_in_n_i) ? idle_ff + 1 : 0;
  end
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      idle_ff <= 0;
    end else begin
      idle_ff <= nxt_idle;
    end
  end
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!reset_n_i);
  ////////////////////////////////////////////////////////////////////////
  a_ext_off: assert property (!ext_fault_in_n_i |-> gate_o == '0)
    else $error("gate on during external fault");
  a_latch_off: assert property (!fault_n_o |-> gate_o == '0)
    else $error("gate on while fault latched");
  a_fault_delay: assert property ($fell(ext_fault_in_n_i) && fault_n_o |-> ##[1:40] !fault_n_o)
    else $error("fault output late");
  a_release_idle: assert property ($rose(fault_n_o) |-> idle_ff >= hb_pkg::IDLE_CYC)
    else $error("latch released without idle span");
  a_chop_od: assert property (chopper_fault_out_n_o == 1'b0)
    else $error("open drain data not low");
  a_chop_cmd: assert property (chopper_fault_oe_o |-> $past(chopper_cmd_in_i))
    else $error("chopper fault without its command");
  a_no_overlap: assert property (interlock_off_n_i && $past(interlock_off_n_i) |-> (gate_o.high & gate_o.low) == 3'h0)
    else $error("both gates of a bridge on");
  a_dead_min: assert property ($rose(gate_o.low[0]) && interlock_off_n_i |-> $past(gate_o.high[0], 25) == 1'b0)
    else $error("dead time too short");
  // bus answer one cycle after the request, then a one-cycle ack
  a_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("bus ack missing");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("bus ack longer than one cycle");
  c_latch: cover property ($fell(fault_n_o));
  c_release: cover property ($rose(fault_n_o));
  c_chop: cover property (chopper_fault_oe_o);
  c_dead: cover property ($rose(gate_o.low[0]));
endmodule

bind halfbridge_interlock_fault_latch hb_chk u_chk (
  .mclk_i, .reset_n_i, .cmd_i, .chopper_cmd_in_i, .ext_fault_in_n_i, .interlock_off_n_i,
  .gate_o, .fault_n_o, .chopper_fault_out_n_o, .chopper_fault_oe_o, .wb_cyc_i, .wb_stb_i,
  .wb_ack_o
);

// >>> dv/host_model.sv
// host controller model: command drive and the wired fault node
module host_model (
  input  wire logic            mclk_i,
  input  wire logic            reset_n_i,
  input  wire hb_pkg::bridge_t req_i,
  input  wire logic            chop_req_i,
  input  wire logic            ext_req_n_i,
  input  wire logic            od_i,
  input  wire logic            oe_i,
  output hb_pkg::bridge_t      cmd_o,
  output logic                 chop_o,
  output logic                 ext_n_o
);
  timeunit 1ns;
  timeprecision 1ns;
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cmd_o  <= '0;
      chop_o <= 1'b0;
    end else begin
      cmd_o  <= req_i;
      chop_o <= chop_req_i;
    end
  end
  assign ext_n_o = ext_req_n_i & (oe_i ? od_i : 1'b1);
endmodule

// >>> dv/tb.sv
// testbench: interlock, dead time, fault latch, chopper fault and registers
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk_i = 1'b0;
  logic reset_n_i = 1'b0;
  hb_pkg::bridge_t req = '0;
  hb_pkg::bridge_t cmd_i, gate_o;
  logic chop_req = 1'b0;
  logic ext_req_n = 1'b1;
  logic chopper_cmd_in_i, ext_fault_in_n_i, chopper_gate_o, fault_n_o, irq_o, wb_ack_o;
  logic chopper_fault_out_n_o, chopper_fault_oe_o;
  logic deadtime_strap_a_n_i = 1'b1;
  logic deadtime_strap_b_n_i = 1'b1;
  logic interlock_off_n_i = 1'b1;
  logic [6:0] desat_i = 7'h00;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'h1;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd;
  int errors = 0;
  int n_tests = 0;
  int n;
  int b;
  int dt [4] = '{25, 50, 75, 100};
  always #20 mclk_i = ~mclk_i;
  halfbridge_interlock_fault_latch dut (.mclk_i, .reset_n_i, .cmd_i, .chopper_cmd_in_i,
    .ext_fault_in_n_i, .deadtime_strap_a_n_i, .deadtime_strap_b_n_i, .interlock_off_n_i,
    .desat_i, .gate_o, .chopper_gate_o, .fault_n_o, .chopper_fault_out_n_o,
    .chopper_fault_oe_o, .irq_o, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
    .wb_dat_i, .wb_dat_o, .wb_ack_o);
  host_model host (.mclk_i, .reset_n_i, .req_i(req), .chop_req_i(chop_req),
    .ext_req_n_i(ext_req_n), .od_i(chopper_fault_out_n_o), .oe_i(chopper_fault_oe_o),
    .cmd_o(cmd_i), .chop_o(chopper_cmd_in_i), .ext_n_o(ext_fault_in_n_i));
  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // one classic cycle; held until ack is sampled, then one idle cycle
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    int t;
    t = 0;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do begin
      @(posedge mclk_i);
      t++;
    end while (wb_ack_o !== 1'b1 && t < 20);
    chk("bus ack", 1, t < 20);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
    @(posedge mclk_i);
  endtask
  task automatic set_cmd(input logic [5:0] c);
    req <= hb_pkg::bridge_t'(c);
    @(posedge mclk_i);
  endtask
  task automatic wait_fault(input logic lvl, input int lim);
    n = 0;
    while (fault_n_o !== lvl && n < lim) begin
      @(posedge mclk_i);
      n++;
    end
  endtask
  task automatic test_done;
    $display("comparisons %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // watchdog: the whole sequence needs well under 5000 cycles
  initial begin
    repeat (20000) @(posedge mclk_i);
    errors++;
    $display("[FAIL] watchdog expected finish seen hang");
    test_done();
  end
  initial begin
    repeat (12) @(posedge mclk_i);
    reset_n_i <= 1'b1;
    @(posedge mclk_i);
    wb(1'b0, hb_pkg::REG_CTRL, 32'h0);
    chk("ctrl reset", 32'h1, rd);
    wb(1'b0, 8'h14, 32'h0);
    chk("unmapped read", 32'h0, rd);
    chk("fault idle high", 1, fault_n_o);
    $display("test reset done");
    // dead counters only start at reset release: let them run out first
    repeat (110) @(posedge mclk_i);
    for (int k = 0; k < 4; k++) begin
      b = k % 3;
      {deadtime_strap_a_n_i, deadtime_strap_b_n_i} <= 2'(k);
      set_cmd(6'(8 << b));
      repeat (2) @(posedge mclk_i);
      chk("high gate on", 32'(8 << b), 32'(gate_o));
      set_cmd(6'(1 << b));
      n = 0;
      while (gate_o.low[b] !== 1'b1 && n < 300) begin
        @(posedge mclk_i);
        n++;
      end
      chk("dead time", 1, n >= dt[k] && n <= dt[k] + 5);
      set_cmd(6'h00);
      repeat (4) @(posedge mclk_i);
    end
    $display("test dead time done");
    interlock_off_n_i <= 1'b0;
    set_cmd(6'h3F);
    repeat (2) @(posedge mclk_i);
    chk("no interlock", 32'h3F, 32'(gate_o));
    set_cmd(6'h00);
    repeat (3) @(posedge mclk_i);
    interlock_off_n_i <= 1'b1;
    wb(1'b1, hb_pkg::REG_IRQ_EN, 32'h1);
    set_cmd(6'h10);
    repeat (110) @(posedge mclk_i);
    chk("gate before fault", 32'h10, 32'(gate_o));
    ext_req_n <= 1'b0;
    @(posedge mclk_i);
    chk("ext fault gates", 32'h0, 32'(gate_o));
    wait_fault(1'b0, 100);
    chk("fault delay", 1, n >= 28 && n <= 39);
    ext_req_n <= 1'b1;
    repeat (700) @(posedge mclk_i);
    chk("held while commanded", 0, fault_n_o);
    chk("irq raised", 1, irq_o);
    set_cmd(6'h00);
    wait_fault(1'b1, 1000);
    chk("release time", 1, n >= 600 && n <= 650);
    wb(1'b0, hb_pkg::REG_IRQ_STAT, 32'h0);
    chk("irq status", 32'h3, rd);
    wb(1'b1, hb_pkg::REG_IRQ_CLR, 32'h1);
    chk("irq masked", 0, irq_o);
    wb(1'b1, hb_pkg::REG_IRQ_CLR, 32'h2);
    wb(1'b0, hb_pkg::REG_IRQ_STAT, 32'h0);
    chk("irq cleared", 32'h0, rd);
    $display("test latch done");
    chop_req <= 1'b1;
    desat_i <= 7'h40;
    n = 0;
    while (chopper_fault_oe_o !== 1'b1 && n < 200) begin
      @(posedge mclk_i);
      n++;
    end
    chk("chopper blanking", 1, n >= 88 && n <= 100);
    chk("chopper gate cut", 0, chopper_gate_o);
    wait_fault(1'b0, 100);
    chk("chopper shuts six", 0, fault_n_o);
    chop_req <= 1'b0;
    desat_i <= 7'h00;
    repeat (3) @(posedge mclk_i);
    chk("chopper fault follows cmd", 0, chopper_fault_oe_o);
    repeat (180) @(posedge mclk_i);
    chop_req <= 1'b1;
    repeat (3) @(posedge mclk_i);
    chk("chopper released", 1, chopper_gate_o);
    chop_req <= 1'b0;
    $display("test chopper done");
    test_done();
  end
endmodule
